// >>> logic/ecam_consts.svh
// Constants for the cam engage/disengage block: register indexes, fields,
// reset values and timing. Included by bare name from the logic/ folder.
`ifndef ECAM_CONSTS_SVH
`define ECAM_CONSTS_SVH

// Register indexes; byte address is four times the index
`define IDX_INITIAL_LEAD   14'h05ae
`define IDX_SETTINGS       14'h05b0
`define IDX_THRESHOLD      14'h05b2
`define IDX_AREA_POS       14'h05b4
`define IDX_AREA_NEG       14'h05b6
`define IDX_CYCLIC_LEAD    14'h05b8
`define IDX_MACRO_ARG4     14'h05ba

// Settings word fields from the bottom, one hex digit each except the path, which takes two
`define F_ENABLE           0
`define F_SOURCE_LSB       4
`define F_TIMING_LSB       8
`define F_DISENGAGE_LSB    12
`define F_PATH_LSB         16
`define F_STATUS_LSB       28

// Reset values
`define RST_SETTINGS       24'h000000
`define RST_THRESHOLD      32'h00000000
`define RST_AREA           16'h0000
`define RST_LEAD           32'h00000000
`define RST_MACRO_ARG      32'h00000000

// Bus answers
`define AXI_OKAY           2'b00
`define AXI_SLVERR         2'b10

// Internal time base: 1 ms at a 20 ns clock
`define TICK_PERIOD_NS     1000000
`define CLK_PERIOD_NS      20
`define TICK_CYCLES        (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// >>> logic/ecam_pkg.sv
// Types shared by the cam engage/disengage logic.
// Assumes the constants header is included by each design file that needs it.
package ecam_pkg;

    typedef enum logic [1:0]
    {
        ST_STOP    = 2'b00,
        ST_ENGAGED = 2'b01,
        ST_LEAD    = 2'b10
    } cam_state_t;

    typedef struct packed {
        logic [15:0] tick_cnt;
        logic        fwd;
        logic        rev;
    } pulse_sel_t;

    typedef struct packed {
        logic        aw_pend;
        logic [15:0] aw_addr;
        logic        w_pend;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        b_valid;
        logic [1:0]  b_resp;
        logic        r_valid;
        logic [31:0] r_data;
        logic [1:0]  r_resp;
        logic [23:0] settings;
        logic [31:0] threshold;
        logic [15:0] area_pos;
        logic [15:0] area_neg;
        logic [31:0] cyclic_lead;
        logic [31:0] macro_arg;
        logic [31:0] initial_lead;
        cam_state_t  state;
        logic        armed;
        logic [31:0] lead_len;
        logic [31:0] lead_cnt;
        logic [31:0] travel;
        logic        launch;
        logic [5:0]  path;
        logic        speed_hold;
    } ctrl_state_t;

endpackage

// >>> logic/master_pulse_select.sv
// Master axis pulse selector with the internal 1 ms time base.
// Assumes source pulses are one-cycle strobes synchronous to sys_clk.
`include "ecam_consts.svh"

module master_pulse_select #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] source,
    input  wire logic [4:0] ext_fwd,
    input  wire logic [4:0] ext_rev,
    output logic            fwd,
    output logic            rev
);

    ecam_pkg::pulse_sel_t r_reg;
    ecam_pkg::pulse_sel_t r_next;

    always_comb
    begin
        r_next = r_reg;
        r_next.tick_cnt = (r_reg.tick_cnt == 16'(TICK_CYCLES - 1)) ? 16'h0000
                        : r_reg.tick_cnt + 16'h0001;
        r_next.fwd = 1'b0;
        r_next.rev = 1'b0;
        // Codes 6 and 7 select nothing; gear sees no master motion
        case (source)
            3'h0, 3'h1, 3'h2, 3'h3:
            begin
                r_next.fwd = ext_fwd[source[1:0]];
                r_next.rev = ext_rev[source[1:0]];
            end
            3'h4:
            begin
                r_next.fwd = (r_reg.tick_cnt == 16'(TICK_CYCLES - 1));
            end
            3'h5:
            begin
                r_next.fwd = ext_fwd[4];
                r_next.rev = ext_rev[4];
            end
            default:
            begin
                r_next.fwd = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign fwd = r_reg.fwd;
    assign rev = r_reg.rev;

endmodule

// >>> logic/ecam_engage_disengage_control.sv
// Electronic cam engage/disengage control with an AXI4-Lite register slave.
// Assumes discrete inputs and master pulses are synchronous to sys_clk.
//
// The AXI4-Lite slave port was decided locally.
`include "ecam_consts.svh"

// What this block does
// - Lowest settings digit enables the cam: 0 off, 1 on.
// - Source digit picks master: capture, encoder, pulse, path, 1 ms base, sync.
// - Engage timing: 0 at once, 1 on cam-on input, 2 on capture event.
// - Disengage codes add up; 2, 4 and 6 never together; field 0 to 15.
// - Code 2: disengage when master travel reaches signed threshold, then stop.
// - Code 6: as code 2 but speed held, slight overshoot, then stop.
// - Code 4: travel beyond threshold disengages and returns to lead.
// - Code 8: clear cam enable after disengaging.
// - Servo off, fault, limit or homing disengage and clear enable.
// - Codes 2, 4, 6 launch the follow-on motion path unless it is 00.
// - Read-only status digit: 0 stop, 1 engaged, 2 lead.
// - Disengage threshold is signed and software keeps it in range.
// - After code 4, re-engage once pulses exceed the cyclic lead length.
// - Positive lead counts forward pulses, negative counts reverse pulses.
// - First engage waits in lead until pulses exceed the initial lead length.
module ecam_engage_disengage_control #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        capture_fwd,
    input  wire logic        capture_rev,
    input  wire logic        encoder_fwd,
    input  wire logic        encoder_rev,
    input  wire logic        pulse_cmd_fwd,
    input  wire logic        pulse_cmd_rev,
    input  wire logic        motion_path_fwd,
    input  wire logic        motion_path_rev,
    input  wire logic        sync_axis_fwd,
    input  wire logic        sync_axis_rev,
    input  wire logic        cam_on,
    input  wire logic        cam_off,
    input  wire logic        capture_event,
    input  wire logic        servo_off,
    input  wire logic        servo_fault,
    input  wire logic        fwd_limit,
    input  wire logic        rev_limit,
    input  wire logic        homing,
    output logic [1:0]       engage_status,
    output logic             gear_engaged,
    output logic             path_launch,
    output logic [5:0]       path_number,
    output logic             speed_hold
);

    ecam_pkg::ctrl_state_t r_reg;
    ecam_pkg::ctrl_state_t r_next;

    logic        m_fwd;
    logic        m_rev;
    logic        en;
    logic [3:0]  timing;
    logic [3:0]  disengage;
    logic [5:0]  path_sel;
    logic        safety;
    logic        go;
    logic        dir_pulse;
    logic [31:0] lead_mag;
    logic [31:0] cnt_step;
    logic [31:0] travel_step;
    logic        reach;
    logic        beyond;
    logic        drop;

    function automatic logic [13:0] reg_index(input logic [15:0] addr);
        return addr[15:2];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
            if (s[i])
                m[i*8 +: 8] = d[i*8 +: 8];
        return m;
    endfunction

    function automatic logic mapped(input logic [13:0] idx);
        return idx == `IDX_INITIAL_LEAD || idx == `IDX_SETTINGS
            || idx == `IDX_THRESHOLD || idx == `IDX_AREA_POS
            || idx == `IDX_AREA_NEG || idx == `IDX_CYCLIC_LEAD
            || idx == `IDX_MACRO_ARG4;
    endfunction

    master_pulse_select #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_pulse_sel (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .source  (r_reg.settings[`F_SOURCE_LSB +: 3]),
        .ext_fwd ({sync_axis_fwd, motion_path_fwd, pulse_cmd_fwd,
                   encoder_fwd, capture_fwd}),
        .ext_rev ({sync_axis_rev, motion_path_rev, pulse_cmd_rev,
                   encoder_rev, capture_rev}),
        .fwd     (m_fwd),
        .rev     (m_rev)
    );

    // Field split of the settings word
    assign en        = r_reg.settings[`F_ENABLE];
    assign timing    = r_reg.settings[`F_TIMING_LSB +: 4];
    assign disengage = r_reg.settings[`F_DISENGAGE_LSB +: 4];
    assign path_sel  = r_reg.settings[`F_PATH_LSB +: 6];

    assign safety = servo_off | servo_fault | fwd_limit | rev_limit | homing;
    assign go     = (timing == 4'h0) | ((timing == 4'h1) & cam_on)
                  | ((timing == 4'h2) & capture_event);

    // Lead direction follows the sign of the lead length
    assign dir_pulse   = r_reg.lead_len[31] ? m_rev : m_fwd;
    assign lead_mag    = r_reg.lead_len[31] ? 32'(-r_reg.lead_len) : r_reg.lead_len;
    assign cnt_step    = r_reg.lead_cnt + {31'h0, dir_pulse};
    assign travel_step = r_reg.travel + (m_fwd ? 32'h00000001 : 32'h00000000)
                       - (m_rev ? 32'h00000001 : 32'h00000000);

    // Sign of the threshold gives the direction of travel
    assign reach  = r_reg.threshold[31] ? ($signed(travel_step) <= $signed(r_reg.threshold))
                  : ($signed(travel_step) >= $signed(r_reg.threshold));
    assign beyond = r_reg.threshold[31] ? ($signed(travel_step) < $signed(r_reg.threshold))
                  : ($signed(travel_step) > $signed(r_reg.threshold));

    always_comb
    begin
        r_next = r_reg;
        r_next.launch = 1'b0;
        drop = 1'b0;

        // Write channel: address and data taken in either order
        if (s_axi_bvalid && s_axi_bready)
            r_next.b_valid = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            r_next.aw_pend = 1'b1;
            r_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            r_next.w_pend = 1'b1;
            r_next.w_data = s_axi_wdata;
            r_next.w_strb = s_axi_wstrb;
        end
        if (r_reg.aw_pend && r_reg.w_pend && !r_reg.b_valid)
        begin
            r_next.aw_pend = 1'b0;
            r_next.w_pend  = 1'b0;
            r_next.b_valid = 1'b1;
            r_next.b_resp  = mapped(reg_index(r_reg.aw_addr)) ? `AXI_OKAY : `AXI_SLVERR;
            case (reg_index(r_reg.aw_addr))
                `IDX_SETTINGS:
                begin
                    // Zero digit and status digit are not writable
                    r_next.settings = 24'(merge({8'h00, r_reg.settings},
                                                r_reg.w_data, r_reg.w_strb));
                end
                `IDX_THRESHOLD:
                begin
                    r_next.threshold = merge(r_reg.threshold, r_reg.w_data,
                                             r_reg.w_strb);
                end
                `IDX_AREA_POS:
                begin
                    r_next.area_pos = 16'(merge({16'h0000, r_reg.area_pos},
                                                r_reg.w_data, r_reg.w_strb));
                end
                `IDX_AREA_NEG:
                begin
                    r_next.area_neg = 16'(merge({16'h0000, r_reg.area_neg},
                                                r_reg.w_data, r_reg.w_strb));
                end
                `IDX_CYCLIC_LEAD:
                begin
                    r_next.cyclic_lead = merge(r_reg.cyclic_lead, r_reg.w_data,
                                               r_reg.w_strb);
                end
                `IDX_MACRO_ARG4:
                begin
                    r_next.macro_arg = merge(r_reg.macro_arg, r_reg.w_data, r_reg.w_strb);
                end
                `IDX_INITIAL_LEAD:
                begin
                    r_next.initial_lead = merge(r_reg.initial_lead, r_reg.w_data,
                                                r_reg.w_strb);
                end
                default:
                begin
                    r_next.b_resp = `AXI_SLVERR;
                end
            endcase
        end

        // Read channel: one word per request, answered next cycle
        if (s_axi_rvalid && s_axi_rready)
            r_next.r_valid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            r_next.r_valid = 1'b1;
            r_next.r_resp  = mapped(reg_index(s_axi_araddr)) ? `AXI_OKAY : `AXI_SLVERR;
            case (reg_index(s_axi_araddr))
                `IDX_SETTINGS:
                    r_next.r_data = {2'b00, r_reg.state, 4'h0, r_reg.settings};
                `IDX_THRESHOLD:
                    r_next.r_data = r_reg.threshold;
                `IDX_AREA_POS:
                    r_next.r_data = {16'h0000, r_reg.area_pos};
                `IDX_AREA_NEG:
                    r_next.r_data = {16'h0000, r_reg.area_neg};
                `IDX_CYCLIC_LEAD:
                    r_next.r_data = r_reg.cyclic_lead;
                `IDX_MACRO_ARG4:
                    r_next.r_data = r_reg.macro_arg;
                `IDX_INITIAL_LEAD:
                    r_next.r_data = r_reg.initial_lead;
                default:
                    r_next.r_data = 32'h00000000;
            endcase
        end

        // Re-arm only while disabled so a stopped cam does not restart by itself
        if (!en)
            r_next.armed = 1'b1;

        if (safety)
        begin
            r_next.state = ecam_pkg::ST_STOP;
            r_next.settings[`F_ENABLE] = 1'b0;
        end
        else if (!en)
        begin
            r_next.state = ecam_pkg::ST_STOP;
        end
        else
        begin
            unique case (r_reg.state)
                ecam_pkg::ST_STOP:
                begin
                    if (r_reg.armed && go)
                    begin
                        r_next.armed      = 1'b0;
                        r_next.state      = ecam_pkg::ST_LEAD;
                        r_next.lead_len   = r_reg.initial_lead;
                        r_next.lead_cnt   = 32'h00000000;
                        r_next.speed_hold = 1'b0;
                    end
                end
                ecam_pkg::ST_LEAD:
                begin
                    r_next.lead_cnt = cnt_step;
                    if (cnt_step > lead_mag)
                    begin
                        r_next.state  = ecam_pkg::ST_ENGAGED;
                        r_next.travel = 32'h00000000;
                    end
                end
                ecam_pkg::ST_ENGAGED:
                begin
                    r_next.travel = travel_step;
                    if (disengage[0] && cam_off)
                    begin
                        r_next.state = ecam_pkg::ST_STOP;
                        drop = 1'b1;
                    end
                    else
                    begin
                        // Only one of 2, 4, 6 may be present
                        unique case (disengage[2:1])
                            2'b01, 2'b11:
                            begin
                                if (reach)
                                begin
                                    r_next.state      = ecam_pkg::ST_STOP;
                                    r_next.speed_hold = disengage[2];
                                    r_next.launch     = path_sel != 6'h00;
                                    drop = 1'b1;
                                end
                            end
                            2'b10:
                            begin
                                if (beyond)
                                begin
                                    r_next.state    = ecam_pkg::ST_LEAD;
                                    r_next.lead_len = r_reg.cyclic_lead;
                                    r_next.lead_cnt = 32'h00000000;
                                    r_next.launch   = path_sel != 6'h00;
                                    drop = 1'b1;
                                end
                            end
                            2'b00:
                            begin
                                r_next.launch = 1'b0;
                            end
                        endcase
                    end
                    // Hardware clear wins over a software write in the same cycle
                    if (drop && disengage[3])
                        r_next.settings[`F_ENABLE] = 1'b0;
                    if (drop)
                        r_next.path = path_sel;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_reg              <= '0;
            r_reg.settings     <= `RST_SETTINGS;
            r_reg.threshold    <= `RST_THRESHOLD;
            r_reg.area_pos     <= `RST_AREA;
            r_reg.area_neg     <= `RST_AREA;
            r_reg.cyclic_lead  <= `RST_LEAD;
            r_reg.initial_lead <= `RST_LEAD;
            r_reg.macro_arg    <= `RST_MACRO_ARG;
            r_reg.state        <= ecam_pkg::ST_STOP;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign s_axi_awready = !r_reg.aw_pend;
    assign s_axi_wready  = !r_reg.w_pend;
    assign s_axi_bvalid  = r_reg.b_valid;
    assign s_axi_bresp   = r_reg.b_resp;
    assign s_axi_arready = !r_reg.r_valid;
    assign s_axi_rvalid  = r_reg.r_valid;
    assign s_axi_rdata   = r_reg.r_data;
    assign s_axi_rresp   = r_reg.r_resp;

    assign engage_status = r_reg.state;
    assign gear_engaged  = r_reg.state == ecam_pkg::ST_ENGAGED;
    assign path_launch   = r_reg.launch;
    assign path_number   = r_reg.path;
    assign speed_hold    = r_reg.speed_hold;

endmodule

// >>> verif/ecam_checker.sv
// Port checker for the cam block.
// Bound into the top module; reset active low.
module ecam_checker (
    input logic        sys_clk,
    input logic        rst_n,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic        servo_off,
    input logic        servo_fault,
    input logic        fwd_limit,
    input logic        rev_limit,
    input logic        homing,
    input logic [1:0]  engage_status,
    input logic        gear_engaged,
    input logic        path_launch,
    input logic [5:0]  path_number,
    input logic        speed_hold
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_status_code: assert property (engage_status != 2'b11)
        else $error("bad status");
    a_gear_level: assert property (gear_engaged == (engage_status == 2'b01))
        else $error("gear level");
    a_launch_pulse: assert property (path_launch |=> !path_launch)
        else $error("long launch");
    a_launch_path: assert property (path_launch |-> path_number != 6'h00)
        else $error("launch path zero");
    a_launch_leaves: assert property (path_launch |->
        engage_status != 2'b01 && $past(engage_status) == 2'b01)
        else $error("stray launch");
    a_safety_stop: assert property
        (servo_off || servo_fault || fwd_limit || rev_limit || homing |=> engage_status == 2'b00)
        else $error("no safety stop");
    a_hold_stop: assert property ($rose(speed_hold) |->
        engage_status == 2'b00 && $past(engage_status) == 2'b01)
        else $error("stray hold");
    a_engage_lead: assert property ($rose(gear_engaged) |-> $past(engage_status) == 2'b10)
        else $error("no lead");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
endmodule

bind ecam_engage_disengage_control ecam_checker chk (.*);

// >>> verif/pulse_source.sv
// Master pulse model: spaced one-cycle strobes.
// Bench starts each burst.
module pulse_source (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic [2:0] src,
    input  wire logic       start,
    input  wire logic       dir,
    input  wire logic [7:0] count,
    output logic [7:0]      fwd_o,
    output logic [7:0]      rev_o,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left;
    logic       stb;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left <= 8'h00;
            stb  <= 1'b0;
        end
        else if (start)
            left <= count;
        else
        begin
            // Gap keeps strobes distinct
            stb <= (left != 8'h00) && !stb;
            if (stb)
                left <= left - 8'h01;
        end
    end
    assign busy  = (left != 8'h00);
    assign fwd_o = (stb && !dir) ? (8'h01 << src) : 8'h00;
    assign rev_o = (stb && dir) ? (8'h01 << src) : 8'h00;
endmodule

// >>> verif/testbench.sv
// Bench for the cam block.
// Short time base in simulation.
`include "ecam_consts.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] awaddr = 16'h0000;
    logic [15:0] araddr = 16'h0000;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, launch, engaged, shold, busy;
    logic [1:0]  bresp, rresp, status;
    logic [31:0] rdata;
    logic [5:0]  pnum;
    logic [5:0]  launched = 6'h00;
    logic        cam_on = 1'b0, cam_off = 1'b0, start = 1'b0, dir = 1'b0;
    logic [4:0]  safety = 5'h00;
    logic [2:0]  src = 3'h0;
    logic [7:0]  count = 8'h00;
    logic [7:0]  fv, rv;
    int          errors = 0;
    int          n_checks = 0;

    always #10 sys_clk = ~sys_clk;

    pulse_source model (.sys_clk(sys_clk), .rst_n(rst_n), .src(src), .start(start),
        .dir(dir), .count(count), .fwd_o(fv), .rev_o(rv), .busy(busy));

    ecam_engage_disengage_control #(.TICK_CYCLES(8)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .capture_fwd(fv[0]), .capture_rev(rv[0]), .encoder_fwd(fv[1]), .encoder_rev(rv[1]),
        .pulse_cmd_fwd(fv[2]), .pulse_cmd_rev(rv[2]), .motion_path_fwd(fv[3]),
        .motion_path_rev(rv[3]), .sync_axis_fwd(fv[5]), .sync_axis_rev(rv[5]),
        .cam_on(cam_on), .cam_off(cam_off), .capture_event(1'b0), .servo_off(safety[0]),
        .servo_fault(safety[1]), .fwd_limit(safety[2]), .rev_limit(safety[3]),
        .homing(safety[4]), .engage_status(status), .gear_engaged(engaged),
        .path_launch(launch), .path_number(pnum), .speed_hold(shold));

    always @(posedge sys_clk)
        if (launch === 1'b1)
            launched <= pnum;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [13:0] idx, input logic [31:0] d,
                      input logic [1:0] er = `AXI_OKAY);
        logic a;
        logic w;
        @(posedge sys_clk);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(negedge sys_clk);
            a = awvalid && awready;
            w = wvalid && wready;
            @(posedge sys_clk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        while (awvalid && !a || wvalid && !w);
        bready <= 1'b1;
        do @(negedge sys_clk); while (!bvalid);
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge sys_clk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [13:0] idx, input logic [31:0] exp);
        @(posedge sys_clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do @(negedge sys_clk); while (!arready);
        @(posedge sys_clk);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(negedge sys_clk); while (!rvalid);
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, (idx == 14'h0) ? `AXI_SLVERR : `AXI_OKAY});
        @(posedge sys_clk);
        rready <= 1'b0;
    endtask

    task automatic pulses(input logic [2:0] s, input logic d, input logic [7:0] n);
        @(posedge sys_clk);
        src <= s;
        dir <= d;
        count <= n;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        do @(negedge sys_clk); while (busy);
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #400us;
        errors++;
        final_report();
    end

    initial
    begin
        logic [3:0]  cd;
        logic [31:0] cw;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`IDX_SETTINGS, 32'h0);
        rd(`IDX_CYCLIC_LEAD, 32'h0);
        rd(14'h0, 32'h0);
        wr(14'h0, 32'h1, `AXI_SLVERR);
        wr(`IDX_THRESHOLD, 32'hc0000000);
        rd(`IDX_THRESHOLD, 32'hc0000000);
        wr(`IDX_AREA_POS, 32'hffff0168);
        rd(`IDX_AREA_POS, 32'h00000168);
        wr(`IDX_INITIAL_LEAD, 32'h2);
        wr(`IDX_THRESHOLD, 32'h3);
        for (cd = 4'h2; cd != 4'ha; cd += 4'h4)
        begin
            cw = {8'h00, 8'h15, cd, 12'h021};
            launched = 6'h00;
            wr(`IDX_SETTINGS, 32'h0);
            wr(`IDX_SETTINGS, cw | 32'hff000000);
            rd(`IDX_SETTINGS, cw | 32'h20000000);
            pulses(3'h2, 1'b0, 8'h3);
            rd(`IDX_SETTINGS, cw | 32'h10000000);
            pulses(3'h2, 1'b0, 8'h3);
            rd(`IDX_SETTINGS, cw);
            chk({26'h0, launched}, 32'h15);
            chk({31'h0, shold}, {31'h0, cd == 4'h6});
        end
        wr(`IDX_CYCLIC_LEAD, 32'hfffffffe);
        wr(`IDX_SETTINGS, 32'h0);
        wr(`IDX_SETTINGS, 32'h4011);
        pulses(3'h1, 1'b0, 8'h3);
        pulses(3'h1, 1'b0, 8'h4);
        rd(`IDX_SETTINGS, 32'h20004011);
        pulses(3'h1, 1'b0, 8'h3);
        pulses(3'h1, 1'b1, 8'h2);
        rd(`IDX_SETTINGS, 32'h20004011);
        pulses(3'h1, 1'b1, 8'h1);
        rd(`IDX_SETTINGS, 32'h10004011);
        wr(`IDX_SETTINGS, 32'h0);
        wr(`IDX_SETTINGS, 32'h9151);
        rd(`IDX_SETTINGS, 32'h9151);
        cam_on <= 1'b1;
        rd(`IDX_SETTINGS, 32'h20009151);
        pulses(3'h5, 1'b0, 8'h3);
        cam_off <= 1'b1;
        @(posedge sys_clk);
        cam_off <= 1'b0;
        cam_on <= 1'b0;
        rd(`IDX_SETTINGS, 32'h9150);
        for (int i = 0; i < 5; i++)
        begin
            wr(`IDX_SETTINGS, 32'h41);
            repeat (40) @(posedge sys_clk);
            rd(`IDX_SETTINGS, 32'h10000041);
            safety[i] <= 1'b1;
            @(posedge sys_clk);
            safety <= 5'h00;
            rd(`IDX_SETTINGS, 32'h40);
        end
        final_report();
    end
endmodule
